// ---- core_regs_pkg.sv ----
package core_regs_pkg;
  localparam int DATA_W = 8;
  localparam int TRIM_W = 7;
  // Status field positions
  localparam int ST_C = 0;
  localparam int ST_HALF = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDOG = 4;
  localparam int ST_PAGE = 5;
  localparam int ST_CMPW = 6;
  localparam int ST_PINW = 7;
  localparam int NIB_W = 4;
  // Configuration field positions
  localparam int CF_WAKE_N = 7;
  localparam int CF_PULL_N = 6;
  localparam int CF_SRC = 5;
  localparam int CF_EDGE = 4;
  localparam int CF_TGT = 3;
  localparam int CF_RATE_HI = 2;
  localparam int PAGE_BIT = 9;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] ST_RESET = 8'h18;
  localparam logic [6:0] TRIM_RESET = 7'h7F;
  localparam logic [7:0] ST_WR_MASK = 8'hE0;
  localparam logic [7:0] ST_FLAG_MASK = 8'h07;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_RRF = 4'h3,
    OP_RLF = 4'h4,
    OP_LOGIC = 4'h5
  } alu_op_t;

  typedef struct packed {
    alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
  } alu_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic zero;
    logic half;
    logic carry;
    logic sets_z;
    logic sets_dc_c;
  } alu_res_t;

  typedef struct packed {
    logic pin_wake_enable_n;
    logic pin_pullup_enable_n;
    logic timer_source_select;
    logic timer_edge_select;
    logic prescaler_target;
    logic [2:0] prescale_rate;
  } cfg_t;

  typedef struct packed {
    logic [7:0] status;
    cfg_t cfg;
    logic [6:0] trim;
  } core_state_t;
endpackage

// ---- flag_alu.sv ----
`timescale 1ns/1ps
module flag_alu (
  // Operation in
  input core_regs_pkg::alu_req_t req,
  // Result and flags out
  output core_regs_pkg::alu_res_t res
);
  import core_regs_pkg::*;
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    res = '0;
    sum = '0;
    nib = '0;
    unique case (req.op)
      OP_ADD: begin
        sum = {1'b0, req.a} + {1'b0, req.b};
        nib = {1'b0, req.a[NIB_W-1:0]} + {1'b0, req.b[NIB_W-1:0]};
        res.result = sum[7:0];
        res.half = nib[NIB_W];
        res.carry = sum[8];
        res.sets_z = 1'b1;
        res.sets_dc_c = 1'b1;
      end
      OP_SUB: begin
        // Result is b - a; flags hold inverted borrow
        sum = {1'b0, req.b} - {1'b0, req.a};
        nib = {1'b0, req.b[NIB_W-1:0]} - {1'b0, req.a[NIB_W-1:0]};
        res.result = sum[7:0];
        res.half = ~nib[NIB_W];
        res.carry = ~sum[8];
        res.sets_z = 1'b1;
        res.sets_dc_c = 1'b1;
      end
      OP_RRF: begin
        res.result = {req.carry_in, req.a[7:1]};
        res.carry = req.a[0];
        res.sets_dc_c = 1'b1;
      end
      OP_RLF: begin
        res.result = {req.a[6:0], req.carry_in};
        res.carry = req.a[7];
        res.sets_dc_c = 1'b1;
      end
      OP_LOGIC: begin
        res.result = req.b;
        res.sets_z = 1'b1;
      end
      OP_NONE: begin
        res.result = req.b;
      end
      default: begin
        res.result = req.b;
      end
    endcase
    res.zero = (res.result == 8'h00);
  end
endmodule

// ---- pin_cfg_gate.sv ----
`timescale 1ns/1ps
module pin_cfg_gate #(
  parameter int PINS = 4
) (
  // Configuration and direction
  input core_regs_pkg::cfg_t cfg,
  input wire logic [PINS-1:0] pin_direction,
  // Per-pin enables
  output logic [PINS-1:0] pin_wake_en,
  output logic [PINS-1:0] pin_pull_en
);
  import core_regs_pkg::*;
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      // Output pins lose wake and pull-up whatever the enables say
      assign pin_wake_en[i] = ~cfg.pin_wake_enable_n & pin_direction[i];
      assign pin_pull_en[i] = ~cfg.pin_pullup_enable_n & pin_direction[i];
    end
  endgenerate
endmodule

// ---- core_status_option_trim_regs.sv ----
`timescale 1ns/1ps
module core_status_option_trim_regs #(
  parameter int PINS = 4,
  parameter int EXT_PIN = 2
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por_event,
  input wire logic pin_wake_reset,
  input wire logic cmp_wake_reset,
  // Instruction execution
  input core_regs_pkg::alu_req_t alu_req,
  input wire logic dest_status,
  input wire logic dest_trim,
  input wire logic cfg_load,
  input wire logic [7:0] w_acc,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic watchdog_timeout,
  // Pin direction
  input wire logic [PINS-1:0] pin_direction,
  // Register reads and ALU result
  output logic [7:0] status_rd,
  output logic [7:0] trim_rd,
  output logic [7:0] alu_result,
  // Configuration effects
  output core_regs_pkg::cfg_t cfg_out,
  output logic page_base_hi,
  output logic signed [6:0] trim_code,
  output logic [PINS-1:0] pin_wake_en,
  output logic [PINS-1:0] pin_pull_en,
  output logic [PINS-1:0] pin_direction_eff,
  output logic timer_uses_ext_clock,
  output logic timer_count_falling,
  output logic prescale_on_watchdog,
  output logic [8:0] timer_prescale_div,
  output logic [7:0] watchdog_prescale_div
);
  import core_regs_pkg::*;

  core_state_t s_q;
  core_state_t s_d;
  alu_res_t res;
  logic [7:0] st_wr;
  logic [8:0] wdog_div_full;

  // Shift amount is four bits wide so that the top timer code does not wrap
  function automatic logic [8:0] rate_div(input logic [2:0] code, input logic timer_side);
    logic [8:0] one;
    logic [3:0] amt;
    one = 9'h001;
    amt = timer_side ? ({1'b0, code} + 4'h1) : {1'b0, code};
    rate_div = one << amt;
  endfunction

  flag_alu u_alu (
    .req(alu_req),
    .res(res)
  );

  pin_cfg_gate #(.PINS(PINS)) u_gate (
    .cfg(s_q.cfg),
    .pin_direction(pin_direction),
    .pin_wake_en(pin_wake_en),
    .pin_pull_en(pin_pull_en)
  );

  always_comb begin
    s_d = s_q;
    st_wr = s_q.status;
    if (dest_status) begin
      // Page and wake bits take ordinary writes; Z takes them only when the op does not set Z, HALF and C only when the op does not set C
      st_wr = (s_q.status & ~ST_WR_MASK) | (res.result & ST_WR_MASK);
      if (!res.sets_z) begin
        st_wr[ST_Z] = res.result[ST_Z];
      end
      if (!res.sets_dc_c) begin
        st_wr[ST_HALF] = res.result[ST_HALF];
        st_wr[ST_C] = res.result[ST_C];
      end
    end
    // Flags produced by the instruction win over the write
    if (res.sets_z) begin
      st_wr[ST_Z] = res.zero;
    end
    if (res.sets_dc_c) begin
      st_wr[ST_C] = res.carry;
      if (alu_req.op == OP_ADD || alu_req.op == OP_SUB) begin
        st_wr[ST_HALF] = res.half;
      end
    end
    if (watchdog_clear_instruction) begin
      st_wr[ST_SLEEP] = 1'b1;
      st_wr[ST_WDOG] = 1'b1;
    end else if (sleep_instruction) begin
      st_wr[ST_SLEEP] = 1'b0;
      st_wr[ST_WDOG] = 1'b1;
    end
    if (watchdog_timeout) begin
      st_wr[ST_WDOG] = 1'b0;
    end
    s_d.status = st_wr;
    if (cfg_load) begin
      s_d.cfg = cfg_t'(w_acc);
    end
    if (dest_trim && !dest_status) begin
      s_d.trim = res.result[DATA_W-1:1];
    end
    if (por_event) begin
      s_d.status[ST_SLEEP] = 1'b1;
      s_d.status[ST_WDOG] = 1'b1;
      s_d.status[ST_PINW] = 1'b0;
      s_d.status[ST_CMPW] = 1'b0;
      s_d.status[ST_PAGE] = 1'b0;
      s_d.cfg = cfg_t'(CFG_RESET);
      s_d.trim = TRIM_RESET;
    end else if (pin_wake_reset || cmp_wake_reset) begin
      s_d.status[ST_PINW] = pin_wake_reset;
      s_d.status[ST_CMPW] = cmp_wake_reset;
      s_d.status[ST_PAGE] = 1'b0;
      s_d.cfg = cfg_t'(CFG_RESET);
      s_d.trim = TRIM_RESET;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q.status <= ST_RESET;
      s_q.cfg <= cfg_t'(CFG_RESET);
      s_q.trim <= TRIM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign status_rd = s_q.status;
  assign trim_rd = {s_q.trim, 1'b0};
  assign trim_code = s_q.trim;
  assign alu_result = res.result;
  assign cfg_out = s_q.cfg;
  assign page_base_hi = s_q.status[ST_PAGE];
  assign timer_uses_ext_clock = s_q.cfg.timer_source_select;
  assign timer_count_falling = s_q.cfg.timer_edge_select;
  assign prescale_on_watchdog = s_q.cfg.prescaler_target;
  assign timer_prescale_div = rate_div(s_q.cfg.prescale_rate, 1'b1);
  assign wdog_div_full = rate_div(s_q.cfg.prescale_rate, 1'b0);
  assign watchdog_prescale_div = wdog_div_full[DATA_W-1:0];

  always_comb begin
    pin_direction_eff = pin_direction;
    if (s_q.cfg.timer_source_select) begin
      pin_direction_eff[EXT_PIN] = 1'b1;
    end
  end

  chk_cfg_load: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_load && !por_event && !pin_wake_reset && !cmp_wake_reset
      |=> cfg_out == $past(w_acc)) else $error("config not loaded");
  chk_cfg_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_load && !por_event && !pin_wake_reset && !cmp_wake_reset
      |=> $stable(cfg_out)) else $error("config changed without load");
  chk_cfg_reset: assert property (@(posedge ref_clk) disable iff (rst)
    por_event |=> cfg_out == cfg_t'(CFG_RESET)) else $error("config not all ones");
  chk_sleep_clear: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_instruction && !watchdog_clear_instruction && !por_event
      |=> !status_rd[ST_SLEEP]) else $error("sleep bit not cleared");
  chk_timeout_flag: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_timeout && !por_event |=> !status_rd[ST_WDOG]) else $error("expiry bit stuck");
  chk_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    res.sets_z |=> status_rd[ST_Z] == ($past(alu_result) == 8'h00)) else $error("zero wrong");
  chk_trim_bit0: assert property (@(posedge ref_clk) disable iff (rst)
    trim_rd[0] == 1'b0) else $error("trim bit0 set");
  chk_pull_out: assert property (@(posedge ref_clk) disable iff (rst)
    (pin_pull_en & ~pin_direction) == '0) else $error("pull-up on output pin");
  chk_ro_bits: assert property (@(posedge ref_clk) disable iff (rst)
    dest_status && !watchdog_clear_instruction && !sleep_instruction && !watchdog_timeout
      && !por_event |=> status_rd[ST_WDOG:ST_SLEEP] == $past(status_rd[ST_WDOG:ST_SLEEP]))
    else $error("read-only bits written");

  // Arithmetic flags
  chk_add_half: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_ADD |=> status_rd[ST_HALF] == (({1'b0, $past(alu_req.a[NIB_W-1:0])}
      + {1'b0, $past(alu_req.b[NIB_W-1:0])}) > 5'h0F)) else $error("add half wrap wrong");

  chk_sub_half: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_SUB |=> status_rd[ST_HALF]
      == ($past(alu_req.b[NIB_W-1:0]) >= $past(alu_req.a[NIB_W-1:0])))
    else $error("sub half wrap wrong");

  chk_add_carry: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_ADD |=> status_rd[ST_C] == (({1'b0, $past(alu_req.a)}
      + {1'b0, $past(alu_req.b)}) > 9'h0FF)) else $error("add carry wrong");

  chk_sub_carry: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_SUB |=> status_rd[ST_C] == ($past(alu_req.b) >= $past(alu_req.a)))
    else $error("sub carry wrong");

  chk_rrf_carry: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_RRF |=> status_rd[ST_C] == $past(alu_req.a[0]))
    else $error("rotate right carry wrong");

  chk_rlf_carry: assert property (@(posedge ref_clk) disable iff (rst)
    alu_req.op == OP_RLF |=> status_rd[ST_C] == $past(alu_req.a[DATA_W-1]))
    else $error("rotate left carry wrong");

  chk_flag_override: assert property (@(posedge ref_clk) disable iff (rst)
    dest_status && alu_req.op == OP_ADD |=> status_rd[ST_Z] == ($past(alu_result) == 8'h00))
    else $error("status write beat zero flag");

  // Reset cause, power and page bits
  chk_clear_bits: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_clear_instruction && !watchdog_timeout
      |=> status_rd[ST_WDOG:ST_SLEEP] == 2'b11) else $error("clear did not set bits");

  chk_sleep_expiry: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_instruction && !watchdog_timeout |=> status_rd[ST_WDOG])
    else $error("sleep did not set expiry bit");

  chk_pin_wake: assert property (@(posedge ref_clk) disable iff (rst)
    pin_wake_reset && !por_event |=> status_rd[ST_PINW])
    else $error("pin wake bit not set");

  chk_cmp_wake: assert property (@(posedge ref_clk) disable iff (rst)
    cmp_wake_reset && !por_event |=> status_rd[ST_CMPW])
    else $error("comparator wake bit not set");

  chk_por_status: assert property (@(posedge ref_clk) disable iff (rst)
    por_event |=> status_rd[ST_PINW:ST_SLEEP] == 5'b00011)
    else $error("power-up status wrong");

  chk_page_write: assert property (@(posedge ref_clk) disable iff (rst)
    dest_status && !por_event && !pin_wake_reset && !cmp_wake_reset
      |=> page_base_hi == $past(alu_result[ST_PAGE])) else $error("page bit not written");

  // Configuration
  chk_wake_cfg: assert property (@(posedge ref_clk) disable iff (rst)
    pin_wake_reset || cmp_wake_reset |=> cfg_out == cfg_t'(CFG_RESET))
    else $error("config not reset by wake");

  chk_wake_off: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_out.pin_wake_enable_n |-> pin_wake_en == '0)
    else $error("wake enabled while disabled");

  chk_wake_on: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_out.pin_wake_enable_n |-> pin_wake_en == pin_direction)
    else $error("wake enable wrong");

  chk_pull_off: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_out.pin_pullup_enable_n |-> pin_pull_en == '0)
    else $error("pull-up on while disabled");

  chk_pull_on: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_out.pin_pullup_enable_n |-> pin_pull_en == pin_direction)
    else $error("pull-up enable wrong");

  chk_ext_dir: assert property (@(posedge ref_clk) disable iff (rst)
    timer_uses_ext_clock |-> pin_direction_eff[EXT_PIN])
    else $error("clock pin not forced to input");

  chk_dir_pass: assert property (@(posedge ref_clk) disable iff (rst)
    !timer_uses_ext_clock |-> pin_direction_eff == pin_direction)
    else $error("direction altered");

  chk_timer_div: assert property (@(posedge ref_clk) disable iff (rst)
    timer_prescale_div[{1'b0, cfg_out.prescale_rate} + 4'h1]
      && $countones(timer_prescale_div) == 1) else $error("timer rate wrong");

  chk_wdog_div: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_prescale_div[cfg_out.prescale_rate]
      && $countones(watchdog_prescale_div) == 1) else $error("watchdog rate wrong");

  // Trim
  chk_trim_reset: assert property (@(posedge ref_clk) disable iff (rst)
    por_event |=> trim_rd == {TRIM_RESET, 1'b0})
    else $error("trim not reset");

  chk_trim_write: assert property (@(posedge ref_clk) disable iff (rst)
    dest_trim && !dest_status && !por_event && !pin_wake_reset && !cmp_wake_reset
      |=> trim_code == $past(alu_result[DATA_W-1:1])) else $error("trim not written");
endmodule

// ---- cpu_stub.sv ----
`timescale 1ns/1ps
module cpu_stub (
  // Clock and ALU result
  input wire logic ref_clk,
  input wire logic [7:0] alu_result,
  // Instruction drive: {sleep, clear, cfg load, to trim, to status}
  output core_regs_pkg::alu_req_t alu_req,
  output logic [4:0] ctl,
  output logic [7:0] w_acc
);
  import core_regs_pkg::*;
  logic trim_done = 1'b0;
  initial begin
    alu_req = '0;
    ctl = '0;
    w_acc = '0;
  end
  // One instruction per call, held for one cycle, then idle
  task automatic exec(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic ci, input logic [4:0] c, output logic [7:0] r);
    @(posedge ref_clk);
    #1;
    if (c[1] && trim_done) begin
      c[1] = 1'b0;
    end
    trim_done = trim_done | c[1];
    alu_req = '{op, a, b, ci};
    ctl = c;
    w_acc = a;
    @(posedge ref_clk);
    r = alu_result;
    #1;
    alu_req = '0;
    ctl = '0;
  endtask
endmodule

// ---- tb_core_status_option_trim_regs.sv ----
`timescale 1ns/1ps
module tb_core_status_option_trim_regs;
  import core_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic por_event = 1'b0;
  logic pin_wake_reset = 1'b0;
  logic cmp_wake_reset = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic [3:0] pin_direction = 4'h0;
  alu_req_t alu_req;
  logic [4:0] ctl;
  logic [7:0] w_acc, status_rd, trim_rd, alu_result, r;
  cfg_t cfg_out;
  logic page_base_hi, timer_uses_ext_clock, timer_count_falling, prescale_on_watchdog;
  logic signed [6:0] trim_code;
  logic [3:0] pin_wake_en, pin_pull_en, pin_direction_eff;
  logic [8:0] timer_prescale_div;
  logic [7:0] watchdog_prescale_div;
  int errors = 0;
  int tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  cpu_stub cpu (.ref_clk(ref_clk), .alu_result(alu_result), .alu_req(alu_req), .ctl(ctl),
    .w_acc(w_acc));
  core_status_option_trim_regs uut (.ref_clk(ref_clk), .rst(rst), .por_event(por_event),
    .pin_wake_reset(pin_wake_reset), .cmp_wake_reset(cmp_wake_reset), .alu_req(alu_req),
    .dest_status(ctl[0]), .dest_trim(ctl[1]), .cfg_load(ctl[2]), .w_acc(w_acc),
    .watchdog_clear_instruction(ctl[3]), .sleep_instruction(ctl[4]),
    .watchdog_timeout(watchdog_timeout), .pin_direction(pin_direction),
    .status_rd(status_rd), .trim_rd(trim_rd), .alu_result(alu_result), .cfg_out(cfg_out),
    .page_base_hi(page_base_hi), .trim_code(trim_code), .pin_wake_en(pin_wake_en),
    .pin_pull_en(pin_pull_en), .pin_direction_eff(pin_direction_eff),
    .timer_uses_ext_clock(timer_uses_ext_clock), .timer_count_falling(timer_count_falling),
    .prescale_on_watchdog(prescale_on_watchdog), .timer_prescale_div(timer_prescale_div),
    .watchdog_prescale_div(watchdog_prescale_div));
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #1 s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
  endtask
  // Runs one flag-producing op and checks result and flags against a local model
  task automatic arith(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic ci);
    logic [8:0] s;
    logic h, c;
    h = 1'b0;
    case (op)
      OP_ADD: begin
        s = a + b;
        h = (a[3:0] + b[3:0]) > 15;
        c = s[8];
      end
      OP_SUB: begin
        s = b - a;
        h = b[3:0] >= a[3:0];
        c = b >= a;
      end
      OP_RRF: begin
        s = {1'b0, ci, a[7:1]};
        c = a[0];
      end
      default: begin
        s = {1'b0, a[6:0], ci};
        c = a[7];
      end
    endcase
    cpu.exec(op, a, b, ci, 5'h00, r);
    chk("alu_result", s[7:0], r);
    chk("carry", c, status_rd[ST_C]);
    if (op == OP_ADD || op == OP_SUB) begin
      chk("half_wrap_bit", h, status_rd[ST_HALF]);
      chk("zero", s[7:0] == 8'h00, status_rd[ST_Z]);
    end
  endtask
  task automatic results();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("status reset", 8'h18, status_rd);
    chk("cfg reset", 8'hFF, cfg_out);
    chk("trim reset", 8'hFE, trim_rd);
    arith(OP_ADD, 8'h0F, 8'h01, 1'b0);
    arith(OP_ADD, 8'hF0, 8'h10, 1'b0);
    arith(OP_ADD, 8'h88, 8'h88, 1'b0);
    arith(OP_SUB, 8'h01, 8'h02, 1'b0);
    arith(OP_SUB, 8'h02, 8'h01, 1'b0);
    arith(OP_SUB, 8'h10, 8'h10, 1'b0);
    arith(OP_RRF, 8'h81, 8'h00, 1'b0);
    arith(OP_RLF, 8'h7E, 8'h00, 1'b1);
    cpu.exec(OP_LOGIC, 8'h00, 8'hFF, 1'b0, 5'h01, r);
    chk("status write", 8'hFB, status_rd);
    chk("page", 1'b1, page_base_hi);
    cpu.exec(OP_ADD, 8'h00, 8'h00, 1'b0, 5'h01, r);
    chk("status add write", 8'h1C, status_rd);
    cpu.exec(OP_NONE, 8'h00, 8'h00, 1'b0, 5'h10, r);
    chk("sleep bits", 2'b10, status_rd[4:3]);
    pulse(watchdog_timeout);
    chk("timeout bits", 2'b00, status_rd[4:3]);
    cpu.exec(OP_NONE, 8'h00, 8'h00, 1'b0, 5'h08, r);
    chk("clear bits", 2'b11, status_rd[4:3]);
    for (int k = 0; k < 8; k++) begin
      cpu.exec(OP_NONE, {5'b00100, k[2:0]}, 8'h00, 1'b0, 5'h04, r);
      chk("cfg_out", {5'b00100, k[2:0]}, cfg_out);
      chk("wake_en out pin", 4'h0, pin_wake_en);
      chk("pull_en out pin", 4'h0, pin_pull_en);
      chk("dir_eff", 4'h4, pin_direction_eff);
      chk("ext clock", 1'b1, timer_uses_ext_clock);
      chk("edge", 1'b0, timer_count_falling);
      chk("target", 1'b0, prescale_on_watchdog);
      chk("timer div", 9'h002 << k, timer_prescale_div);
      chk("wdog div", 9'h001 << k, watchdog_prescale_div);
    end
    @(posedge ref_clk);
    #1 pin_direction = 4'hB;
    #1 chk("wake_en", 4'hB, pin_wake_en);
    chk("pull_en", 4'hB, pin_pull_en);
    cpu.exec(OP_NONE, 8'hDA, 8'h00, 1'b0, 5'h04, r);
    chk("wake_en off", 4'h0, pin_wake_en);
    chk("pull_en off", 4'h0, pin_pull_en);
    chk("dir_eff in", 4'hB, pin_direction_eff);
    chk("edge fall", 1'b1, timer_count_falling);
    chk("target wdog", 1'b1, prescale_on_watchdog);
    cpu.exec(OP_LOGIC, 8'h00, 8'h81, 1'b0, 5'h02, r);
    chk("trim_rd", 8'h80, trim_rd);
    chk("trim_code", 7'sh40, trim_code);
    pulse(pin_wake_reset);
    chk("pin wake", 3'b100, status_rd[7:5]);
    chk("cfg after wake", 8'hFF, cfg_out);
    pulse(cmp_wake_reset);
    chk("cmp wake", 3'b010, status_rd[7:5]);
    pulse(por_event);
    chk("power-up", 5'b00011, status_rd[7:3]);
    results();
  end
endmodule
